//--- hdl/rrsm_regs.sv
// Status, mask, collision position, strength and test registers of the reader.
// Assumes host port strobes and decoder events are synchronous to mclk_i;
// strength comparator codes and the keying/modulation pins are asynchronous.
//
// Behaviour
// - Mask bits 5..1 enable FIFO, CRC, parity, framing, collision; reset to one.
// - Mask bit 0 enables no-response interrupt; resets to zero.
// - Ten-bit position: bits 9,8 in mask bits 7,6, low byte separate.
// - Low position register resets to zero and clears after host read.
// - Outside Type A, position marks the bit of a frame error.
// - Strength valid from reception start until next transmission start.
// - Strength holds peak envelope, readable after packet end.
// - Strength values clear when next transmission starts.
// - Each channel strength is a 3-bit code, 4 dB per step.
// - Main strength code sits in bits 2..0.
// - Auxiliary strength code sits in bits 5..3.
// - Bit 6 of strength reads one after oscillator settles, about 200 us.
// - Input swap makes auxiliary field report the first receive input.
// - Test bit 7 makes keying pin the decoder digital input.
// - Test bit 6 drives digitised subcarrier out on modulation pin.
// - Test bit 5 takes transmit modulation from pin and resets receiver.
// - Test bit 4 selects first or second gain stage output.
// - Test bits 3,2 lower second or first stage gain by 6 dB.
// - Test bit 0 shows gain control level in main strength bits.
// - Interrupt status and line clear on status read; line rises at phase end.
`timescale 1ns/10ps
module rrsm_regs #(
	parameter int OSC_CYCLES = rrsm_pkg::OSC_SETTLE_CYC
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Host register port
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	output logic [7:0] reg_rdata_o,
	// Protocol decoder and transmitter events
	input wire logic tx_start_i,
	input wire logic rx_start_i,
	input wire logic phase_end_i,
	input wire logic [5:0] event_i,
	input wire logic [9:0] event_pos_i,
	input wire logic type_a_mode_i,
	input wire logic status_read_i,
	output logic [5:0] event_status_o,
	output logic irq_o,
	// Receiver analog side
	input wire logic input_swap_i,
	input wire logic [2:0] in1_level_i,
	input wire logic [2:0] in2_level_i,
	input wire logic [2:0] agc_level_i,
	output logic stage_select_o,
	output logic second_stage_gain_reduce_o,
	output logic first_stage_gain_reduce_o,
	output logic follower_test_o,
	output logic rx_reset_o,
	// Pins and digital paths
	input wire logic keying_pin_i,
	input wire logic mod_pin_i,
	input wire logic rx_subcarrier_i,
	input wire logic tx_modulation_i,
	input wire logic internal_decoder_data_i,
	output logic decoder_data_o,
	output logic tx_mod_o,
	output logic mod_pin_o,
	output logic mod_pin_oe_o
);
	localparam int CNT_W = $clog2(OSC_CYCLES + 1);

	typedef struct packed {
		rrsm_pkg::rrsm_hold_t hold;
		logic [7:0] mask;
		logic [7:0] coll_low;
		logic [7:0] test;
		logic [7:0] rdata;
		logic [5:0] status;
		logic irq;
		logic [CNT_W-1:0] osc_cnt;
		logic osc_ok;
		logic decoder_data;
		logic tx_mod;
		logic mod_pin;
		logic mod_pin_oe;
	} rrsm_st_t;

	rrsm_st_t st_ff;
	rrsm_st_t nxt_st;
	logic [8:0] lvl_sync;
	logic [2:0] agc_sync;
	logic [1:0] pin_sync;
	logic [2:0] main_lvl;
	logic [2:0] aux_lvl;
	logic [2:0] main_peak;
	logic [2:0] aux_peak;
	logic [2:0] main_field;
	logic rd_coll;
	logic capture;
	logic [7:0] strength;

	rrsm_sync #(.W(9)) u_lvl_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i({in2_level_i, in1_level_i, agc_level_i}),
		.q_o(lvl_sync)
	);

	rrsm_sync #(.W(2)) u_pin_sync (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.d_i({mod_pin_i, keying_pin_i}),
		.q_o(pin_sync)
	);

	assign agc_sync = lvl_sync[2:0];
	// Swapped inputs trade channel roles
	assign main_lvl = input_swap_i ? lvl_sync[8:6] : lvl_sync[5:3];
	assign aux_lvl = input_swap_i ? lvl_sync[5:3] : lvl_sync[8:6];

	// Peak tracks only while a reception window is open
	rrsm_peak #(.W(rrsm_pkg::STR_W)) u_main_peak (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clear_i(tx_start_i),
		.track_i(st_ff.hold == rrsm_pkg::RRSM_HOLD_RX || rx_start_i),
		.level_i(main_lvl),
		.peak_o(main_peak)
	);

	rrsm_peak #(.W(rrsm_pkg::STR_W)) u_aux_peak (
		.mclk_i(mclk_i),
		.rst_n_i(rst_n_i),
		.clear_i(tx_start_i),
		.track_i(st_ff.hold == rrsm_pkg::RRSM_HOLD_RX || rx_start_i),
		.level_i(aux_lvl),
		.peak_o(aux_peak)
	);

	assign main_field = st_ff.test[rrsm_pkg::TST_AGC] ? agc_sync : main_peak;
	always_comb begin
		strength = 8'h00;
		strength[rrsm_pkg::STR_OSC_OK] = st_ff.osc_ok;
		strength[rrsm_pkg::STR_AUX_LSB +: rrsm_pkg::STR_W] = aux_peak;
		strength[rrsm_pkg::STR_MAIN_LSB +: rrsm_pkg::STR_W] = main_field;
	end

	assign rd_coll = reg_rd_i && (reg_addr_i == rrsm_pkg::OFS_COLL_LOW);
	// Type A logs collisions only; other protocols log frame errors
	assign capture = type_a_mode_i ? event_i[rrsm_pkg::EV_COLL]
		: (|event_i[rrsm_pkg::EV_CRC:rrsm_pkg::EV_FRAMING]);

	always_comb begin
		nxt_st = st_ff;
		// Reception window for the strength capture
		case (st_ff.hold)
			rrsm_pkg::RRSM_HOLD_IDLE: begin
				if (rx_start_i && !tx_start_i) begin
					nxt_st.hold = rrsm_pkg::RRSM_HOLD_RX;
				end
			end
			rrsm_pkg::RRSM_HOLD_RX: begin
				if (tx_start_i) begin
					nxt_st.hold = rrsm_pkg::RRSM_HOLD_IDLE;
				end
			end
			default: begin
				nxt_st.hold = rrsm_pkg::RRSM_HOLD_IDLE;
			end
		endcase

		// Oscillator settle count from reset release
		if (st_ff.osc_cnt < CNT_W'(OSC_CYCLES)) begin
			nxt_st.osc_cnt = st_ff.osc_cnt + 1'b1;
		end else begin
			nxt_st.osc_ok = 1'b1;
		end

		// Host writes; collision bits stay read-only
		if (reg_wr_i) begin
			case (reg_addr_i)
				rrsm_pkg::OFS_MASK: begin
					nxt_st.mask[rrsm_pkg::MASK_EN_HI:0] = reg_wdata_i[rrsm_pkg::MASK_EN_HI:0];
				end
				rrsm_pkg::OFS_TEST: begin
					nxt_st.test = reg_wdata_i;
				end
				default: begin
					nxt_st.test = st_ff.test;
				end
			endcase
		end

		// Clear on read, capture in the same cycle wins
		if (rd_coll) begin
			nxt_st.coll_low = 8'h00;
		end
		if (capture) begin
			nxt_st.coll_low = event_pos_i[7:0];
			nxt_st.mask[rrsm_pkg::MASK_COLLISION_POS_BIT9] = event_pos_i[9];
			nxt_st.mask[rrsm_pkg::MASK_COLLISION_POS_BIT8] = event_pos_i[8];
		end

		// Status records every event, enabled or not
		if (status_read_i) begin
			nxt_st.status = '0;
			nxt_st.irq = 1'b0;
		end
		nxt_st.status = nxt_st.status | event_i;
		// Line rises only at phase end and only for enabled events
		if (phase_end_i && |(nxt_st.status & st_ff.mask[rrsm_pkg::MASK_EN_HI:0])) begin
			nxt_st.irq = 1'b1;
		end

		// Registered read data
		case (reg_addr_i)
			rrsm_pkg::OFS_MASK: nxt_st.rdata = st_ff.mask;
			rrsm_pkg::OFS_COLL_LOW: nxt_st.rdata = st_ff.coll_low;
			rrsm_pkg::OFS_STRENGTH: nxt_st.rdata = strength;
			rrsm_pkg::OFS_TEST: nxt_st.rdata = st_ff.test;
			default: nxt_st.rdata = 8'h00;
		endcase
		if (!reg_rd_i) begin
			nxt_st.rdata = st_ff.rdata;
		end

		// Pin routing under test control
		nxt_st.decoder_data = st_ff.test[rrsm_pkg::TST_KEY_IN] ? pin_sync[0]
			: internal_decoder_data_i;
		nxt_st.tx_mod = st_ff.test[rrsm_pkg::TST_DIRECT] ? pin_sync[1]
			: tx_modulation_i;
		nxt_st.mod_pin_oe = st_ff.test[rrsm_pkg::TST_SUBC_OUT];
		nxt_st.mod_pin = st_ff.test[rrsm_pkg::TST_SUBC_OUT] & rx_subcarrier_i;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st_ff.hold <= rrsm_pkg::RRSM_HOLD_IDLE;
			st_ff.mask <= rrsm_pkg::MASK_RESET;
			st_ff.coll_low <= rrsm_pkg::COLL_LOW_RESET;
			st_ff.test <= rrsm_pkg::TEST_RESET;
			st_ff.rdata <= 8'h00;
			st_ff.status <= '0;
			st_ff.irq <= 1'b0;
			st_ff.osc_cnt <= '0;
			st_ff.osc_ok <= 1'b0;
			st_ff.decoder_data <= 1'b0;
			st_ff.tx_mod <= 1'b0;
			st_ff.mod_pin <= 1'b0;
			st_ff.mod_pin_oe <= 1'b0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign reg_rdata_o = st_ff.rdata;
	assign event_status_o = st_ff.status;
	assign irq_o = st_ff.irq;
	assign stage_select_o = st_ff.test[rrsm_pkg::TST_STAGE_SEL];
	assign second_stage_gain_reduce_o = st_ff.test[rrsm_pkg::TST_GAIN2_LOW];
	assign first_stage_gain_reduce_o = st_ff.test[rrsm_pkg::TST_GAIN1_LOW];
	assign follower_test_o = st_ff.test[rrsm_pkg::TST_FOLLOW];
	assign rx_reset_o = st_ff.test[rrsm_pkg::TST_DIRECT];
	assign decoder_data_o = st_ff.decoder_data;
	assign tx_mod_o = st_ff.tx_mod;
	assign mod_pin_o = st_ff.mod_pin;
	assign mod_pin_oe_o = st_ff.mod_pin_oe;
endmodule : rrsm_regs

//--- hdl/rrsm_pkg.sv
// Constants of the reader status, mask, strength and test register group.
// Assumes a 100 MHz system clock and an 8-bit host register port.
package rrsm_pkg;
	// Register offsets on the host port
	localparam logic [7:0] OFS_MASK = 8'h0d;
	localparam logic [7:0] OFS_COLL_LOW = 8'h0e;
	localparam logic [7:0] OFS_STRENGTH = 8'h0f;
	localparam logic [7:0] OFS_TEST = 8'h1a;
	// Reset values
	localparam logic [7:0] MASK_RESET = 8'h3e;
	localparam logic [7:0] COLL_LOW_RESET = 8'h00;
	localparam logic [7:0] TEST_RESET = 8'h00;
	// Mask register fields
	localparam int MASK_COLLISION_POS_BIT9 = 7;
	localparam int MASK_COLLISION_POS_BIT8 = 6;
	localparam int MASK_EN_HI = 5;
	localparam int MASK_EN_NORESP = 0;
	// Event vector order, same as mask bits 5..0
	localparam int EV_FIFO = 5;
	localparam int EV_CRC = 4;
	localparam int EV_PARITY = 3;
	localparam int EV_FRAMING = 2;
	localparam int EV_COLL = 1;
	localparam int EV_NORESP = 0;
	localparam int EV_W = 6;
	// Strength register fields
	localparam int STR_OSC_OK = 6;
	localparam int STR_AUX_LSB = 3;
	localparam int STR_MAIN_LSB = 0;
	localparam int STR_W = 3;
	// Test register fields
	localparam int TST_KEY_IN = 7;
	localparam int TST_SUBC_OUT = 6;
	localparam int TST_DIRECT = 5;
	localparam int TST_STAGE_SEL = 4;
	localparam int TST_GAIN2_LOW = 3;
	localparam int TST_GAIN1_LOW = 2;
	localparam int TST_FOLLOW = 1;
	localparam int TST_AGC = 0;
	// Oscillator settle time
	localparam int CLK_MHZ = 100;
	localparam int OSC_SETTLE_US = 200;
	localparam int OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_MHZ;
	localparam int COLL_POS_W = 10;

	typedef enum logic [0:0] {
		RRSM_HOLD_IDLE = 1'b0,
		RRSM_HOLD_RX = 1'b1
	} rrsm_hold_t;
endpackage : rrsm_pkg

//--- hdl/rrsm_sync.sv
// Two-flop synchroniser for pins and analog comparator levels.
// Assumes inputs are quasi-static relative to mclk_i.
`timescale 1ns/10ps
module rrsm_sync #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Data
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	typedef struct packed {
		logic [W-1:0] meta;
		logic [W-1:0] q;
	} rrsm_sync_st_t;
	rrsm_sync_st_t st_ff;
	rrsm_sync_st_t nxt_st;

	always_comb begin
		nxt_st.meta = d_i;
		nxt_st.q = st_ff.meta;
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign q_o = st_ff.q;
endmodule : rrsm_sync

//--- hdl/rrsm_peak.sv
// Peak hold of one 3-bit receive strength code.
// Assumes level_i is already synchronous to mclk_i.
`timescale 1ns/10ps
module rrsm_peak #(
	parameter int W = 3
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Control
	input wire logic clear_i,
	input wire logic track_i,
	// Level
	input wire logic [W-1:0] level_i,
	output logic [W-1:0] peak_o
);
	typedef struct packed {
		logic [W-1:0] peak;
	} rrsm_peak_st_t;
	rrsm_peak_st_t st_ff;
	rrsm_peak_st_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (clear_i) begin
			nxt_st.peak = '0;
		end else if (track_i && (level_i > st_ff.peak)) begin
			nxt_st.peak = level_i;
		end
	end

	always_ff @(posedge mclk_i) begin
		if (!rst_n_i) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign peak_o = st_ff.peak;
endmodule : rrsm_peak

//--- testbench/rrsm_props.sv
// Port checker of the reader register group.
// Sees only rrsm_regs ports; attached by the bind below.
`timescale 1ns/10ps
module rrsm_props #(
	parameter int OSC_CYCLES = 20
) (
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_n_i,
	// Watched ports
	input wire logic [7:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic [7:0] reg_rdata_o,
	input wire logic tx_start_i,
	input wire logic rx_start_i,
	input wire logic phase_end_i,
	input wire logic [5:0] event_i,
	input wire logic status_read_i,
	input wire logic [5:0] event_status_o,
	input wire logic irq_o,
	input wire logic stage_select_o,
	input wire logic rx_reset_o
);
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_n_i);
	a_status_records: assert property (|event_i |=>
		(event_status_o & $past(event_i)) == $past(event_i)) else $error("event lost");
	a_irq_at_phase: assert property ($rose(irq_o) |-> $past(phase_end_i))
		else $error("irq outside phase end");
	a_read_clears: assert property (status_read_i && !phase_end_i && event_i == 6'h00
		|=> !irq_o && event_status_o == 6'h00) else $error("status not cleared");
	a_unused_zero: assert property (reg_rd_i && reg_addr_i == 8'h0f
		|=> !reg_rdata_o[7]) else $error("unused bit set");
	a_strength_clear: assert property (tx_start_i && !rx_start_i ##1 !rx_start_i
		##1 (reg_rd_i && reg_addr_i == 8'h0f && !rx_start_i)
		|=> reg_rdata_o[5:3] == 3'h0) else $error("strength kept");
	a_low_clears: assert property ((reg_rd_i && reg_addr_i == 8'h0e && event_i == 6'h00)
		##1 event_i == 6'h00 ##1 (reg_rd_i && reg_addr_i == 8'h0e && event_i == 6'h00)
		|=> reg_rdata_o == 8'h00) else $error("position not cleared");
	a_test_levels: assert property (reg_wr_i && reg_addr_i == 8'h1a
		|=> stage_select_o == $past(reg_wdata_i[4]) && rx_reset_o == $past(reg_wdata_i[5]))
		else $error("test bits not applied");
	a_reset_quiet: assert property ($rose(rst_n_i)
		|-> !irq_o && event_status_o == 6'h00 && reg_rdata_o == 8'h00) else $error("reset");
endmodule : rrsm_props
bind rrsm_regs rrsm_props #(.OSC_CYCLES(OSC_CYCLES)) i_props (.mclk_i, .rst_n_i, .reg_addr_i,
	.reg_wr_i, .reg_rd_i, .reg_wdata_i, .reg_rdata_o, .tx_start_i, .rx_start_i, .phase_end_i,
	.event_i, .status_read_i, .event_status_o, .irq_o, .stage_select_o, .rx_reset_o);

//--- testbench/rrsm_host.sv
// Host model: one-cycle register strobes launched on falling edges.
// Assumes read data registered one rising edge after the strobe.
`timescale 1ns/10ps
module rrsm_host (
	// Clock
	input wire logic mclk_i,
	// Register port
	output logic [7:0] addr_o,
	output logic wr_o,
	output logic rd_o,
	output logic [7:0] wdata_o,
	input wire logic [7:0] rdata_i
);
	initial begin
		{addr_o, wr_o, rd_o, wdata_o} = '0;
	end
	task automatic xfer(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		@(negedge mclk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = w;
		rd_o = !w;
		@(negedge mclk_i);
		{wr_o, rd_o} = 2'b00;
		// Released lines must not keep the old value
		addr_o = ~a;
		wdata_o = ~d;
		q = rdata_i;
	endtask : xfer
endmodule : rrsm_host

//--- testbench/tb.sv
// Self-checking bench of the reader register group.
// Inputs change on falling edges; the host model makes register accesses.
`timescale 1ns/10ps
module tb;
	logic mclk_i, rst_n_i, type_a_mode_i, input_swap_i, irq_o;
	logic tx_start_i, rx_start_i, phase_end_i, status_read_i;
	logic keying_pin_i, mod_pin_i, rx_subcarrier_i, tx_modulation_i, internal_decoder_data_i;
	logic [5:0] event_i, event_status_o;
	logic [9:0] event_pos_i;
	logic [2:0] in1_level_i, in2_level_i, agc_level_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic reg_wr_i, reg_rd_i, stage_select_o, second_stage_gain_reduce_o, rx_reset_o;
	logic first_stage_gain_reduce_o, follower_test_o, decoder_data_o;
	logic tx_mod_o, mod_pin_o, mod_pin_oe_o;
	int err_total = 0;
	int tests_run = 0;

	rrsm_regs #(.OSC_CYCLES(20)) i_dut (.mclk_i, .rst_n_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
		.reg_wdata_i, .reg_rdata_o, .tx_start_i, .rx_start_i, .phase_end_i, .event_i,
		.event_pos_i, .type_a_mode_i, .status_read_i, .event_status_o, .irq_o, .input_swap_i,
		.in1_level_i, .in2_level_i, .agc_level_i, .stage_select_o, .second_stage_gain_reduce_o,
		.first_stage_gain_reduce_o, .follower_test_o, .rx_reset_o, .keying_pin_i, .mod_pin_i,
		.rx_subcarrier_i, .tx_modulation_i, .internal_decoder_data_i, .decoder_data_o,
		.tx_mod_o, .mod_pin_o, .mod_pin_oe_o);
	rrsm_host i_host (.mclk_i, .addr_o(reg_addr_i), .wr_o(reg_wr_i), .rd_o(reg_rd_i),
		.wdata_o(reg_wdata_i), .rdata_i(reg_rdata_o));

	initial begin
		mclk_i = 1'b0;
		forever #5 mclk_i = ~mclk_i;
	end

	task automatic chk(input logic [8:0] got, input logic [8:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, d);
		logic [7:0] q;
		i_host.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rd_chk(input logic [7:0] a, e, m);
		logic [7:0] q;
		i_host.xfer(1'b0, a, 8'h00, q);
		chk({1'b0, q & m}, {1'b0, e});
	endtask : rd_chk
	// c: status read, phase end, rx start, tx start
	task automatic ev(input logic [5:0] e, input logic [9:0] p, input logic [3:0] c);
		@(negedge mclk_i);
		event_i = e;
		event_pos_i = p;
		{status_read_i, phase_end_i, rx_start_i, tx_start_i} = c;
		@(negedge mclk_i);
		event_i = 6'h00;
		{status_read_i, phase_end_i, rx_start_i, tx_start_i} = 4'h0;
	endtask : ev
	task automatic irq_chk(input logic [8:0] e);
		repeat (2) @(negedge mclk_i);
		chk({2'b00, event_status_o, irq_o}, e);
	endtask : irq_chk

	task automatic t_reset();
		rd_chk(8'h0f, 8'h00, 8'hc0);
		rd_chk(8'h0d, 8'h3e, 8'hff);
		rd_chk(8'h0e, 8'h00, 8'hff);
		rd_chk(8'h1a, 8'h00, 8'hff);
		rd_chk(8'h33, 8'h00, 8'hff);
		repeat (25) @(negedge mclk_i);
		rd_chk(8'h0f, 8'h40, 8'hc0);
		$display("t_reset end");
	endtask : t_reset
	task automatic t_irq();
		ev(6'h01, 10'h000, 4'h4);
		irq_chk(9'h002);
		ev(6'h00, 10'h000, 4'h8);
		wr(8'h0d, 8'hc1);
		rd_chk(8'h0d, 8'h01, 8'hff);
		ev(6'h10, 10'h000, 4'h4);
		irq_chk(9'h020);
		ev(6'h00, 10'h000, 4'h8);
		irq_chk(9'h000);
		wr(8'h0d, 8'h3f);
		ev(6'h01, 10'h000, 4'h4);
		irq_chk(9'h003);
		ev(6'h00, 10'h000, 4'h8);
		$display("t_irq end");
	endtask : t_irq
	task automatic t_coll();
		ev(6'h04, 10'h2a5, 4'h0);
		rd_chk(8'h0d, 8'hbf, 8'hff);
		rd_chk(8'h0e, 8'ha5, 8'hff);
		rd_chk(8'h0e, 8'h00, 8'hff);
		type_a_mode_i = 1'b1;
		ev(6'h08, 10'h3ff, 4'h0);
		rd_chk(8'h0e, 8'h00, 8'hff);
		ev(6'h02, 10'h155, 4'h8);
		rd_chk(8'h0d, 8'h7f, 8'hff);
		rd_chk(8'h0e, 8'h55, 8'hff);
		$display("t_coll end");
	endtask : t_coll
	task automatic t_strength();
		{in1_level_i, in2_level_i} = {3'h5, 3'h3};
		ev(6'h00, 10'h000, 4'h2);
		repeat (6) @(negedge mclk_i);
		{in1_level_i, in2_level_i} = {3'h1, 3'h0};
		repeat (6) @(negedge mclk_i);
		rd_chk(8'h0f, 8'h5d, 8'hff);
		ev(6'h00, 10'h000, 4'h1);
		rd_chk(8'h0f, 8'h40, 8'hff);
		input_swap_i = 1'b1;
		{in1_level_i, in2_level_i, agc_level_i} = {3'h6, 3'h2, 3'h4};
		ev(6'h00, 10'h000, 4'h2);
		repeat (6) @(negedge mclk_i);
		rd_chk(8'h0f, 8'h72, 8'hff);
		wr(8'h1a, 8'h01);
		repeat (4) @(negedge mclk_i);
		rd_chk(8'h0f, 8'h04, 8'h07);
		$display("t_strength end");
	endtask : t_strength
	task automatic t_test();
		{keying_pin_i, mod_pin_i, rx_subcarrier_i} = 3'b111;
		{tx_modulation_i, internal_decoder_data_i} = 2'b00;
		for (int b = 0; b < 8; b++) begin
			wr(8'h1a, 8'h01 << b);
			repeat (4) @(negedge mclk_i);
			chk({stage_select_o, second_stage_gain_reduce_o, first_stage_gain_reduce_o,
				follower_test_o, rx_reset_o, decoder_data_o, tx_mod_o, mod_pin_o, mod_pin_oe_o},
				{b == 4, b == 3, b == 2, b == 1, b == 5, b == 7, b == 5, b == 6, b == 6});
		end
		rd_chk(8'h1a, 8'h80, 8'hff);
		$display("t_test end");
	endtask : t_test

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : report_and_stop

	initial begin
		#500000;
		err_total++;
		report_and_stop();
	end
	initial begin
		{rst_n_i, type_a_mode_i, input_swap_i, keying_pin_i, mod_pin_i} = '0;
		{rx_subcarrier_i, tx_modulation_i, internal_decoder_data_i} = '0;
		{tx_start_i, rx_start_i, phase_end_i, status_read_i} = '0;
		{event_i, event_pos_i, in1_level_i, in2_level_i, agc_level_i} = '0;
		repeat (10) @(negedge mclk_i);
		rst_n_i = 1'b1;
		t_reset();
		t_irq();
		t_coll();
		t_strength();
		t_test();
		report_and_stop();
	end
endmodule : tb
